// >>> include/ssr_pkg.sv
// Package of constants for the synchronous serial receiver
// What this block does
// - Master receive turns off the data pin driver so the far end drives it.
// - Reception starts when single or continuous receive enable is set.
// - Single enable alone: one character of clocks, then single enable self-clears.
// - Continuous enable keeps clocks running character after character until cleared.
// - Clearing continuous enable mid-character stops the clock and drops partial bits.
// - Both enables set: single clears after first character, continuous then governs.
// - Data pin sampled on trailing clock edge and shifted into shift register.
// - Full character sets receive flag and enters the two-entry FIFO.
// - Data register shows oldest entry low byte; flag stays while FIFO nonempty.
// - Slave mode disables clock pin driver and takes the external clock.
// - Driver changes data on leading edge; one bit per clock cycle.
// - Third character with full FIFO sets overrun and keeps FIFO contents.
// - After overrun both entries stay readable; no reception until cleared.
// - Overrun clears by data read in single mode, by clearing continuous enable.
// - Clearing port enable resets the serial unit and its overrun.
// - Nine-bit select shifts nine bits; ninth bit field shows oldest entry MSB.
// - Completed character raises interrupt request when receive interrupt enable set.
// - Clock source set makes a master driving the clock pin; clear makes slave.
// - Clocked mode select gives synchronous operation with no start or stop bits.
package ssr_pkg;
  localparam logic [2:0] ADDR_RCV_STATUS  = 3'h0;
  localparam logic [2:0] ADDR_RCV_DATA    = 3'h1;
  localparam logic [2:0] ADDR_TX_STATUS   = 3'h2;
  localparam logic [2:0] ADDR_FLAGS       = 3'h3;
  localparam logic [2:0] ADDR_ENABLES     = 3'h4;
  localparam logic [2:0] ADDR_DIVISOR     = 3'h5;
  // receive_status_control bits
  localparam int RS_PORT_EN   = 7;
  localparam int RS_NINE_SEL  = 6;
  localparam int RS_SINGLE    = 5;
  localparam int RS_CONT      = 4;
  localparam int RS_ADDR_DET  = 3;
  localparam int RS_OVERRUN   = 1;
  localparam int RS_NINTH     = 0;
  // transmit_status_control bits
  localparam int TS_CLK_SRC   = 7;
  localparam int TS_SYNC      = 4;
  localparam int TS_HIGH_SPD  = 2;
  localparam int TS_SHIFT_MT  = 1;
  // flag and enable bit position
  localparam int FL_RECEIVE   = 5;
  localparam logic [7:0] TX_STATUS_RESET = 8'h02;
  localparam logic [7:0] BYTE_ZERO       = 8'h00;
  localparam int FIFO_DEPTH   = 2;
  localparam int BITS_EIGHT   = 8;
  localparam int BITS_NINE    = 9;
  localparam int HIGH_SPD_DIV = 4;
  localparam int LOW_SPD_DIV  = 16;
endpackage

// >>> logic/ssr_receiver.sv
// Synchronous serial receiver with Wishbone register access
//
// Decided for this implementation: the Wishbone register port and the register addresses.
`timescale 1ns/1ns
module ssr_receiver
  import ssr_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        data_line_pin_i,
  output logic             data_line_pin_o,
  output logic             data_line_pin_oe_n_o,
  input  wire logic        clock_line_pin_i,
  output logic             clock_line_pin_o,
  output logic             clock_line_pin_oe_n_o,
  output logic             irq_o
);
  typedef enum logic [1:0] {SSR_IDLE, SSR_LOW, SSR_HIGH} ssr_state_t;

  logic [7:0] rcv_ctrl;
  logic [7:0] tx_ctrl;
  logic [7:0] baud_divisor;
  logic [7:0] int_en;
  logic       overrun_flag;
  logic [8:0] fifo_mem [FIFO_DEPTH];
  logic       rd_ptr;
  logic [1:0] fifo_cnt;
  logic [8:0] receive_shift_reg;
  logic [3:0] bit_cnt;
  logic [11:0] div_cnt;
  ssr_state_t state;
  logic [2:0] clk_sync;
  logic [2:0] dat_sync;
  logic       clk_level;

  wire port_en   = rcv_ctrl[RS_PORT_EN];
  wire single_en = rcv_ctrl[RS_SINGLE];
  wire cont_en   = rcv_ctrl[RS_CONT];
  wire is_master = tx_ctrl[TS_CLK_SRC];
  wire sync_mode = tx_ctrl[TS_SYNC];
  wire rx_active = port_en && sync_mode && (single_en || cont_en) && !overrun_flag;
  wire [3:0] char_bits = rcv_ctrl[RS_NINE_SEL] ? 4'(BITS_NINE) : 4'(BITS_EIGHT);

  wire wb_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire [2:0] reg_idx = wb_adr_i[4:2];
  wire lane0    = wb_sel_i[0];
  wire wr_rcv   = wb_req && wb_we_i && lane0 && reg_idx == ADDR_RCV_STATUS;
  wire wr_tx    = wb_req && wb_we_i && lane0 && reg_idx == ADDR_TX_STATUS;
  wire wr_en    = wb_req && wb_we_i && lane0 && reg_idx == ADDR_ENABLES;
  wire wr_div   = wb_req && wb_we_i && lane0 && reg_idx == ADDR_DIVISOR;
  wire rd_data  = wb_req && !wb_we_i && reg_idx == ADDR_RCV_DATA;

  // Bit clock tick: full period (divisor+1)*rate, half per phase
  wire [11:0] div_len = 12'(({4'h0, baud_divisor} + 12'h001) *
                        (tx_ctrl[TS_HIGH_SPD] ? HIGH_SPD_DIV : LOW_SPD_DIV) / 2);
  wire baud_tick = div_cnt >= div_len - 12'h001;

  // Link edges from synchronised clock pin
  wire clk_agree  = clk_sync[2] == clk_sync[1];
  wire slave_rise = clk_agree && clk_sync[1] && !clk_level;
  wire slave_fall = clk_agree && !clk_sync[1] && clk_level;
  wire data_bit   = dat_sync[2];

  // Trailing edge: master drives high then low
  wire master_fall = is_master && state == SSR_HIGH && baud_tick;
  wire sample      = rx_active && (is_master ? master_fall : slave_fall);
  wire [8:0] shifted = rcv_ctrl[RS_NINE_SEL] ? {data_bit, receive_shift_reg[8:1]}
                                             : {1'b0, data_bit, receive_shift_reg[7:1]};
  wire char_done = sample && bit_cnt == char_bits - 4'h1;
  wire push      = char_done && fifo_cnt != 2'(FIFO_DEPTH);
  wire overrun   = char_done && fifo_cnt == 2'(FIFO_DEPTH);
  wire pop       = rd_data && fifo_cnt != 2'h0;
  wire [8:0] head = fifo_mem[rd_ptr];
  wire wr_ptr    = rd_ptr ^ fifo_cnt[0];
  wire cont_cleared = wr_rcv && !wb_dat_i[RS_CONT] && cont_en;
  wire receive_flag = fifo_cnt != 2'h0;
  wire single_ovr_mode = single_en && !cont_en;

  always_ff @(posedge clk_i) begin
    clk_sync <= {clk_sync[1:0], clock_line_pin_i};
    dat_sync <= {dat_sync[1:0], data_line_pin_i};
    if (rst_i) begin
      clk_level <= 1'b0;
    end else if (clk_agree) begin
      clk_level <= clk_sync[1];
    end
  end

  // Control registers; single enable self clears after a character
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rcv_ctrl     <= BYTE_ZERO;
      tx_ctrl      <= TX_STATUS_RESET;
      baud_divisor <= BYTE_ZERO;
      int_en       <= BYTE_ZERO;
    end else begin
      if (wr_rcv) begin
        rcv_ctrl <= {wb_dat_i[7:3], 3'h0};
      end else if (char_done && single_en && !overrun) begin
        rcv_ctrl[RS_SINGLE] <= 1'b0;
      end
      if (wr_tx) begin
        tx_ctrl <= {wb_dat_i[7:4], 1'b0, wb_dat_i[2], 1'b1, 1'b0};
      end
      if (wr_div) begin
        baud_divisor <= wb_dat_i[7:0];
      end
      if (wr_en) begin
        int_en <= wb_dat_i[7:0];
      end
    end
  end

  // Overrun held until read (single) or continuous/port cleared
  always_ff @(posedge clk_i) begin
    if (rst_i || !port_en) begin
      overrun_flag <= 1'b0;
    end else if (overrun) begin
      overrun_flag <= 1'b1;
    end else if (cont_cleared || (wr_rcv && !wb_dat_i[RS_PORT_EN])) begin
      overrun_flag <= 1'b0;
    end else if (rd_data && single_ovr_mode) begin
      overrun_flag <= 1'b0;
    end
  end

  // Two-entry FIFO; overrun leaves contents intact
  always_ff @(posedge clk_i) begin
    if (rst_i || !port_en) begin
      rd_ptr   <= 1'b0;
      fifo_cnt <= 2'h0;
    end else begin
      if (push) begin
        fifo_mem[wr_ptr] <= shifted;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      fifo_cnt <= fifo_cnt + 2'(push) - 2'(pop);
    end
  end

  // Shift LSB first, count bits; drop partial on stop
  always_ff @(posedge clk_i) begin
    if (rst_i || !rx_active) begin
      bit_cnt           <= 4'h0;
      receive_shift_reg <= 9'h000;
    end else if (sample) begin
      receive_shift_reg <= shifted;
      bit_cnt <= char_done ? 4'h0 : bit_cnt + 4'h1;
    end
  end

  // Master clock generator
  always_ff @(posedge clk_i) begin
    if (rst_i || !rx_active || !is_master) begin
      state   <= SSR_IDLE;
      div_cnt <= 12'h000;
    end else begin
      div_cnt <= baud_tick ? 12'h000 : div_cnt + 12'h001;
      case (state)
        SSR_IDLE: begin
          state   <= SSR_LOW;
          div_cnt <= 12'h000;
        end
        SSR_LOW: begin
          if (baud_tick) begin
            state <= SSR_HIGH;
          end
        end
        SSR_HIGH: begin
          if (baud_tick) begin
            if (char_done && !cont_en) begin
              state <= SSR_IDLE;
            end else begin
              state <= SSR_LOW;
            end
          end
        end
        default: begin
          state <= SSR_IDLE;
        end
      endcase
    end
  end

  // Pins: data never driven while receiving, clock driven only as master
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_line_pin_o       <= 1'b0;
      data_line_pin_oe_n_o  <= 1'b1;
      clock_line_pin_o      <= 1'b0;
      clock_line_pin_oe_n_o <= 1'b1;
    end else begin
      data_line_pin_o       <= 1'b0;
      data_line_pin_oe_n_o  <= 1'b1;
      clock_line_pin_o      <= state == SSR_HIGH && rx_active;
      clock_line_pin_oe_n_o <= !(port_en && sync_mode && is_master);
    end
  end

  // Interrupt request follows flag and enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= receive_flag && int_en[FL_RECEIVE];
    end
  end

  // Register read mux; ninth bit from head entry
  wire [7:0] rcv_status_rd = {rcv_ctrl[7:3], 1'b0, overrun_flag, head[8] & receive_flag};
  wire [7:0] rd_byte = (reg_idx == ADDR_RCV_STATUS) ? rcv_status_rd :
                       (reg_idx == ADDR_RCV_DATA)   ? (receive_flag ? head[7:0] : BYTE_ZERO) :
                       (reg_idx == ADDR_TX_STATUS)  ? tx_ctrl :
                       (reg_idx == ADDR_FLAGS)      ? {2'h0, receive_flag, 5'h00} :
                       (reg_idx == ADDR_ENABLES)    ? int_en :
                       (reg_idx == ADDR_DIVISOR)    ? baud_divisor : BYTE_ZERO;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? {24'h000000, rd_byte} : 32'h0000_0000;
    end
  end

  a_fifo_bound: assert property (@(posedge clk_i) disable iff (rst_i)
    fifo_cnt <= 2'(FIFO_DEPTH)) else $error("fifo count exceeds two");
  a_overrun_keeps: assert property (@(posedge clk_i) disable iff (rst_i)
    overrun && !rd_data && !wr_rcv |=> overrun_flag && fifo_cnt == 2'(FIFO_DEPTH)) else $error("overrun lost");
  a_flag_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    push && !pop |=> receive_flag) else $error("flag not set");
  a_single_clears: assert property (@(posedge clk_i) disable iff (rst_i)
    char_done && single_en && !overrun && !wr_rcv |=> !single_en) else $error("single stays");
  a_data_released: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 data_line_pin_oe_n_o) else $error("data pin driven");
  a_slave_clkoff: assert property (@(posedge clk_i) disable iff (rst_i)
    !is_master |=> clock_line_pin_oe_n_o) else $error("slave drives clock");
  a_stop_drops: assert property (@(posedge clk_i) disable iff (rst_i)
    !rx_active |=> bit_cnt == 4'h0 && state == SSR_IDLE) else $error("partial kept");
  a_port_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    !port_en |=> !overrun_flag && fifo_cnt == 2'h0) else $error("unit not reset");
  a_irq_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    receive_flag && int_en[FL_RECEIVE] |=> irq_o) else $error("irq missing");
endmodule

// >>> verif/ssr_peer.sv
// Far-end model: drives the data line and, as master, the link clock
`timescale 1ns/1ns
module ssr_peer (
  input  wire logic ck_i,
  output logic      dat_o,
  output logic      sck_o
);
  logic [8:0] word;
  int         nbits;
  int         idx;
  initial begin
    word = 9'h000;
    nbits = 8;
    idx = 0;
    dat_o = 1'b1;
    sck_o = 1'b0;
  end
  task automatic load(input logic [8:0] w, input int n);
    word = w;
    nbits = n;
    idx = 0;
  endtask
  // Leading edge puts out the next bit, LSB first, ninth last
  always @(posedge ck_i) begin
    dat_o <= word[idx];
    if (idx == nbits - 1) begin
      idx <= 0;
      word <= word + 9'h001;
    end else begin
      idx <= idx + 1;
    end
  end
  // Slave-mode clock, idle low, only as many cycles as bits
  task automatic frame(input int n);
    repeat (n) begin
      #32 sck_o = 1'b1;
      #32 sck_o = 1'b0;
    end
  endtask
endmodule

// >>> verif/test_ssr_receiver.sv
// Testbench for the synchronous serial receiver
`timescale 1ns/1ns
module test_ssr_receiver import ssr_pkg::*;;
  logic        clk_i, rst_i, cyc, stb, we, ack, irq;
  logic [4:0]  adr;
  logic [31:0] wdat, rdat;
  logic        dout, doe_n, cko, ckoe_n, pdat, sck;
  wire logic   ck = ckoe_n ? sck : cko;
  wire logic   dline = doe_n ? pdat : dout;
  int          errors, compares, cycles, edges;
  ssr_receiver u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .data_line_pin_i(dline), .data_line_pin_o(dout), .data_line_pin_oe_n_o(doe_n),
    .clock_line_pin_i(ck), .clock_line_pin_o(cko), .clock_line_pin_oe_n_o(ckoe_n), .irq_o(irq));
  ssr_peer u_peer (.ck_i(ck), .dat_o(pdat), .sck_o(sck));
  always #2 clk_i = ~clk_i;
  always @(posedge ck) edges++;
  task automatic summarize();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      summarize();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [2:0] idx, input logic [7:0] d, output logic [31:0] r);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h000000, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [2:0] idx, input logic [7:0] d);
    logic [31:0] v;
    wb(1'b1, idx, d, v);
  endtask
  task automatic rchk(input logic [2:0] idx, input logic [31:0] exp);
    logic [31:0] v;
    wb(1'b0, idx, 8'h00, v);
    check(v, exp);
  endtask
  task automatic wait_bit(input logic [2:0] idx, input int b);
    logic [31:0] v;
    v = 32'h00000000;
    for (int n = 0; n < 300 && v[b] !== 1'b1; n++) wb(1'b0, idx, 8'h00, v);
  endtask
  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    {cyc, stb, we} = 3'h0;
    adr = 5'h00;
    wdat = 32'h00000000;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk(ADDR_TX_STATUS, {24'h000000, TX_STATUS_RESET});
    rchk(ADDR_RCV_DATA, 32'h00000000);
    rchk(ADDR_FLAGS, 32'h00000000);
    rchk(3'h7, 32'h00000000);
    wr(ADDR_DIVISOR, 8'h03);
    wr(ADDR_TX_STATUS, 8'h94);
    wr(ADDR_ENABLES, 8'h20);
    wr(ADDR_RCV_STATUS, 8'h80);
    @(posedge clk_i);
    check({31'h0, ckoe_n}, 32'h00000000);
    check({31'h0, doe_n}, 32'h00000001);
    u_peer.load(9'h0a5, 8);
    edges = 0;
    wr(ADDR_RCV_STATUS, 8'ha0);
    wait_bit(ADDR_FLAGS, FL_RECEIVE);
    check({31'h0, irq}, 32'h00000001);
    rchk(ADDR_RCV_STATUS, 32'h00000080);
    check(32'(edges), 32'h00000008);
    rchk(ADDR_RCV_DATA, 32'h000000a5);
    rchk(ADDR_FLAGS, 32'h00000000);
    u_peer.load(9'h03c, 8);
    wr(ADDR_RCV_STATUS, 8'hb0);
    wait_bit(ADDR_RCV_STATUS, RS_OVERRUN);
    rchk(ADDR_RCV_STATUS, 32'h00000092);
    rchk(ADDR_RCV_DATA, 32'h0000003c);
    rchk(ADDR_RCV_DATA, 32'h0000003d);
    rchk(ADDR_FLAGS, 32'h00000000);
    wr(ADDR_RCV_STATUS, 8'h80);
    rchk(ADDR_RCV_STATUS, 32'h00000080);
    edges = 0;
    repeat (40) @(posedge clk_i);
    check(32'(edges), 32'h00000000);
    wr(ADDR_TX_STATUS, 8'h10);
    @(posedge clk_i);
    check({31'h0, ckoe_n}, 32'h00000001);
    wr(ADDR_RCV_STATUS, 8'hd0);
    u_peer.load(9'h1a5, 9);
    u_peer.frame(9);
    wait_bit(ADDR_FLAGS, FL_RECEIVE);
    rchk(ADDR_RCV_STATUS, 32'h000000d1);
    rchk(ADDR_RCV_DATA, 32'h000000a5);
    summarize();
  end
endmodule
